//--- hdl/iorb_map.vh
// register map, field positions and reset values of the low i/o register bank
`ifndef IORB_MAP_VH
`define IORB_MAP_VH
`define IORB_ADDR_CONV_CSB 5'h03
`define IORB_ADDR_CONV_RESL 5'h04
`define IORB_ADDR_CONV_RESH 5'h05
`define IORB_ADDR_CONV_CSA 5'h06
`define IORB_ADDR_CONV_MUX 5'h07
`define IORB_ADDR_CMP_CS 5'h08
`define IORB_ADDR_SER_CTRL 5'h0d
`define IORB_ADDR_SER_STAT 5'h0e
`define IORB_ADDR_SER_DATA 5'h0f
`define IORB_ADDR_SER_BUF 5'h10
`define IORB_ADDR_GP0 5'h11
`define IORB_ADDR_GP1 5'h12
`define IORB_ADDR_GP2 5'h13
`define IORB_ADDR_DIN_DIS 5'h14
`define IORB_ADDR_PC_MASK 5'h15
`define IORB_ADDR_PORT_IN 5'h16
`define IORB_ADDR_PORT_DIR 5'h17
`define IORB_ADDR_PORT_OUT 5'h18
// write-one-to-clear flag positions
`define IORB_W1C_CONV_CSA 8'h10
`define IORB_W1C_CMP_CS 8'h10
`define IORB_W1C_SER_STAT 8'he0
// writable bits (reserved and read-only bits excluded)
`define IORB_WMASK_CONV_CSB 8'he7
`define IORB_WMASK_CONV_CSA 8'hef
`define IORB_WMASK_CMP_CS 8'hcb
`define IORB_WMASK_SER_STAT 8'h0f
`define IORB_WMASK_PORT 8'h3f
`define IORB_WMASK_DIN_DIS 8'h3f
// comparator output bit is hardware driven
`define IORB_CMP_OUT_BIT 5
`define IORB_RESET_VALUE 8'h00
`endif

//--- hdl/iorb_flag.v
// one byte of write-one-to-clear status flags, hardware set wins over clear
`default_nettype none
module iorb_flag (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] mask,
    input wire [7:0] set_pulse,
    input wire [7:0] clear_bits,
    output reg [7:0] flags
);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 8'h00;
        end else begin
            // set beats clear so an event landing on the clear cycle survives
            flags <= ((flags & ~clear_bits) | set_pulse) & mask;
        end
    end
endmodule // iorb_flag
`default_nettype wire

//--- hdl/iorb_bank.v
// low i/o register bank with byte and single-bit access
// Contract
// - set_io_bit and clear_io_bit work on addresses 0x00 to 0x1f only
// - a selected bit is returned for the skip-if-set and skip-if-clear tests
// - status flags clear on writing one, writing zero leaves them
// - bit set or clear changes only the addressed bit; a bit set on a flag clears just that flag
`include "iorb_map.vh"
`default_nettype none
module iorb_bank (
    input wire core_clk,
    input wire rst_n,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire [7:0] io_wdata,
    input wire io_rd,
    output reg [7:0] io_rdata,
    input wire bit_set,
    input wire bit_clr,
    input wire [2:0] bit_sel,
    output wire bit_value,
    output wire bit_access_error,
    input wire [7:0] port_pins,
    input wire [9:0] conv_result,
    input wire conv_done,
    input wire cmp_out,
    input wire cmp_event,
    input wire [2:0] ser_events,
    input wire [7:0] ser_buffer,
    output reg [7:0] port_out,
    output reg [7:0] port_dir,
    output reg [7:0] pc_mask,
    output reg [7:0] din_disable,
    output reg [7:0] conv_csa,
    output reg [7:0] conv_csb,
    output reg [7:0] conv_mux,
    output reg [7:0] cmp_ctrl,
    output reg [7:0] ser_ctrl,
    output reg [7:0] ser_data,
    output reg [3:0] ser_count
);
    // =====================================================================
    // pin synchronisers
    // =====================================================================
    reg [7:0] pin_meta;
    reg [7:0] pin_sync;
    reg [7:0] gp0;
    reg [7:0] gp1;
    reg [7:0] gp2;
    wire [7:0] conv_flags;
    wire [7:0] cmp_flags;
    wire [7:0] ser_flags;
    wire [7:0] cur_value;
    wire [7:0] wr_value;
    wire byte_wr;
    wire any_bit;
    wire in_range;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= port_pins;
            pin_sync <= pin_meta;
        end
    end

    // =====================================================================
    // access decode
    // =====================================================================
    assign in_range = (io_addr[5] == 1'b0);
    assign any_bit = (bit_set | bit_clr) & in_range;
    assign bit_access_error = (bit_set | bit_clr) & ~in_range;
    // addresses above the bank alias onto it through the low bits, so they are cut here
    assign byte_wr = io_wr & ~(bit_set | bit_clr) & in_range;

    function [7:0] read_reg;
        input [4:0] a;
        begin
            case (a)
                `IORB_ADDR_CONV_CSB: read_reg = conv_csb;
                `IORB_ADDR_CONV_RESL: read_reg = conv_result[7:0];
                `IORB_ADDR_CONV_RESH: read_reg = {6'h00, conv_result[9:8]};
                `IORB_ADDR_CONV_CSA: read_reg = conv_csa | conv_flags;
                `IORB_ADDR_CONV_MUX: read_reg = conv_mux;
                `IORB_ADDR_CMP_CS: read_reg = cmp_ctrl | cmp_flags | {2'h0, cmp_out, 5'h00};
                `IORB_ADDR_SER_CTRL: read_reg = ser_ctrl;
                `IORB_ADDR_SER_STAT: read_reg = ser_flags | {4'h0, ser_count};
                `IORB_ADDR_SER_DATA: read_reg = ser_data;
                `IORB_ADDR_SER_BUF: read_reg = ser_buffer;
                `IORB_ADDR_GP0: read_reg = gp0;
                `IORB_ADDR_GP1: read_reg = gp1;
                `IORB_ADDR_GP2: read_reg = gp2;
                `IORB_ADDR_DIN_DIS: read_reg = din_disable;
                `IORB_ADDR_PC_MASK: read_reg = pc_mask;
                `IORB_ADDR_PORT_IN: read_reg = pin_sync & `IORB_WMASK_PORT;
                `IORB_ADDR_PORT_DIR: read_reg = port_dir;
                `IORB_ADDR_PORT_OUT: read_reg = port_out;
                default: read_reg = 8'h00;
            endcase
        end
    endfunction

    function [7:0] onehot;
        input [2:0] b;
        begin
            onehot = 8'h01 << b;
        end
    endfunction

    assign cur_value = read_reg(io_addr[4:0]);
    assign bit_value = in_range & cur_value[bit_sel];

    // bit access rewrites the addressed bit only; flag clear uses just that bit
    assign wr_value = bit_set ? (cur_value | onehot(bit_sel)) :
                      bit_clr ? (cur_value & ~onehot(bit_sel)) : io_wdata;

    // w1c clear vector: byte writes use data, bit set clears only its own flag
    function [7:0] w1c_clear;
        input [4:0] a;
        input [4:0] target;
        input [7:0] mask;
        begin
            if (a != target) begin
                w1c_clear = 8'h00;
            end else if (any_bit) begin
                w1c_clear = bit_set ? (onehot(bit_sel) & mask) : 8'h00;
            end else if (byte_wr) begin
                w1c_clear = io_wdata & mask;
            end else begin
                w1c_clear = 8'h00;
            end
        end
    endfunction

    // =====================================================================
    // status flags
    // =====================================================================
    iorb_flag u_conv_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mask(`IORB_W1C_CONV_CSA),
        .set_pulse({3'h0, conv_done, 4'h0}),
        .clear_bits(w1c_clear(io_addr[4:0], `IORB_ADDR_CONV_CSA, `IORB_W1C_CONV_CSA)),
        .flags(conv_flags)
    );

    iorb_flag u_cmp_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mask(`IORB_W1C_CMP_CS),
        .set_pulse({3'h0, cmp_event, 4'h0}),
        .clear_bits(w1c_clear(io_addr[4:0], `IORB_ADDR_CMP_CS, `IORB_W1C_CMP_CS)),
        .flags(cmp_flags)
    );

    iorb_flag u_ser_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mask(`IORB_W1C_SER_STAT),
        .set_pulse({ser_events, 5'h00}),
        .clear_bits(w1c_clear(io_addr[4:0], `IORB_ADDR_SER_STAT, `IORB_W1C_SER_STAT)),
        .flags(ser_flags)
    );

    // =====================================================================
    // plain registers
    // =====================================================================
    // one strobe per register; an unused or reserved address matches no process
    function wr_hit;
        input [4:0] target;
        begin
            wr_hit = (byte_wr | any_bit) & (io_addr[4:0] == target);
        end
    endfunction

    // reserved positions are masked so they keep reading zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_csb <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_CONV_CSB)) begin
            conv_csb <= wr_value & `IORB_WMASK_CONV_CSB;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_csa <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_CONV_CSA)) begin
            conv_csa <= wr_value & `IORB_WMASK_CONV_CSA;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_mux <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_CONV_MUX)) begin
            conv_mux <= wr_value;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_ctrl <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_CMP_CS)) begin
            cmp_ctrl <= wr_value & `IORB_WMASK_CMP_CS;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_ctrl <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_SER_CTRL)) begin
            ser_ctrl <= wr_value;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_count <= 4'h0;
        end else if (wr_hit(`IORB_ADDR_SER_STAT)) begin
            ser_count <= wr_value[3:0];
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_data <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_SER_DATA)) begin
            ser_data <= wr_value;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp0 <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_GP0)) begin
            gp0 <= wr_value;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp1 <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_GP1)) begin
            gp1 <= wr_value;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp2 <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_GP2)) begin
            gp2 <= wr_value;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_disable <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_DIN_DIS)) begin
            din_disable <= wr_value & `IORB_WMASK_DIN_DIS;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_mask <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_PC_MASK)) begin
            pc_mask <= wr_value & `IORB_WMASK_PORT;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_dir <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_PORT_DIR)) begin
            port_dir <= wr_value & `IORB_WMASK_PORT;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_out <= `IORB_RESET_VALUE;
        end else if (wr_hit(`IORB_ADDR_PORT_OUT)) begin
            port_out <= wr_value & `IORB_WMASK_PORT;
        end
    end

    // =====================================================================
    // read data
    // =====================================================================
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            io_rdata <= in_range ? cur_value : 8'h00;
        end
    end
endmodule // iorb_bank
`default_nettype wire

//--- bench/iorb_bank_asserts.sv
// port assertions of the low i/o register bank
`default_nettype none
module iorb_bank_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic bit_set,
    input wire logic bit_clr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_value,
    input wire logic bit_access_error,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_dir
);
timeunit 1ns;
timeprecision 1ns;
// ====
// checks
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
wire logic no_bit = !bit_set && !bit_clr;
wire logic rsvd = io_addr < 6'h03 || io_addr > 6'h18 || (io_addr > 6'h08 && io_addr < 6'h0d);
a_err_flag_decode: assert property (bit_access_error == (!no_bit && io_addr[5]))
    else $error("bit access error flag wrong");
a_high_bit_zero: assert property (io_addr[5] |-> !bit_value)
    else $error("bit value seen above bit range");
a_high_no_write: assert property (!no_bit && io_addr == 6'h38 |=> $stable(port_out))
    else $error("high address bit op changed port");
a_set_one_bit: assert property (bit_set && !bit_clr && io_addr == 6'h18 && bit_sel < 3'h6
    |=> port_out == ($past(port_out) | (8'h01 << $past(bit_sel)))) else $error("bit set wrong");
a_clr_one_bit: assert property (bit_clr && !bit_set && io_addr == 6'h17
    |=> port_dir == ($past(port_dir) & ~(8'h01 << $past(bit_sel)))) else $error("bit clear wrong");
a_port_bit_test: assert property (io_addr == 6'h18 |-> bit_value == port_out[bit_sel])
    else $error("selected bit differs");
a_dir_byte_write: assert property (io_wr && no_bit && io_addr == 6'h17
    |=> port_dir == ($past(io_wdata) & 8'h3f)) else $error("direction write wrong");
a_dir_read_back: assert property (io_rd && !io_wr && no_bit && io_addr == 6'h17
    |=> io_rdata == $past(port_dir)) else $error("direction read wrong");
a_rsvd_read_zero: assert property (io_rd && rsvd |=> io_rdata == 8'h00)
    else $error("reserved address read nonzero");
a_rsvd_bits_zero: assert property (port_out[7:6] == 2'h0 && port_dir[7:6] == 2'h0)
    else $error("reserved port bits set");
endmodule // iorb_bank_asserts
bind iorb_bank iorb_bank_asserts i_iorb_bank_asserts (.core_clk(core_clk), .rst_n(rst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata),
    .bit_set(bit_set), .bit_clr(bit_clr), .bit_sel(bit_sel), .bit_value(bit_value),
    .bit_access_error(bit_access_error), .port_out(port_out), .port_dir(port_dir));
`default_nettype wire

//--- bench/iorb_core_model.sv
// core model issuing byte and single-bit i/o accesses
`default_nettype none
module iorb_core_model (
    input wire logic core_clk,
    input wire logic [7:0] io_rdata,
    input wire logic bit_value,
    input wire logic bit_access_error,
    output logic [5:0] io_addr,
    output logic io_wr,
    output logic [7:0] io_wdata,
    output logic io_rd,
    output logic bit_set,
    output logic bit_clr,
    output logic [2:0] bit_sel
);
timeunit 1ns;
timeprecision 1ns;
// ====
// access task: request held over one rising edge, then released
initial {io_addr, io_wr, io_wdata, io_rd, bit_set, bit_clr, bit_sel} = 21'h0;
// reserved bits stay zero and reserved places unwritten unless a refusal case asks
task op(input logic [1:0] k, input logic [5:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic bv, output logic er);
    @(negedge core_clk);
    {io_rd, io_wr, bit_set, bit_clr} = {k == 2'h0, k == 2'h1, k == 2'h2, k == 2'h3};
    io_addr = a;
    io_wdata = d;
    bit_sel = d[2:0];
    #1;
    bv = bit_value;
    er = bit_access_error;
    @(negedge core_clk);
    q = io_rdata;
    {io_rd, io_wr, bit_set, bit_clr} = 4'h0;
    // released data no longer shows the old value
    io_wdata = ~d;
endtask
endmodule // iorb_core_model
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench of the low i/o register bank
`default_nettype none
module tb_top;
timeunit 1ns;
timeprecision 1ns;
logic core_clk = 1'b0, rst_n = 1'b0, io_wr, io_rd, bit_set, bit_clr, bit_value, bit_access_error, bv, er;
logic [5:0] io_addr, a;
logic [2:0] bit_sel, ser_events = 3'h0;
logic [7:0] io_wdata, io_rdata, q, d, port_pins = 8'h00, ser_buffer = 8'h00, m [0:63];
logic [9:0] conv_result = 10'h000;
logic conv_done = 1'b0, cmp_out = 1'b0, cmp_event = 1'b0;
logic [31:0] seed = 32'h000106c6, r;
logic [7:0] port_out, port_dir, pc_mask, din_disable, conv_csa, conv_csb;
logic [7:0] conv_mux, cmp_ctrl, ser_ctrl, ser_data, mk;
logic [3:0] ser_count;
logic [1:0] k;
logic [5:0] tbl [0:16] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h17, 6'h18, 6'h00, 6'h02, 6'h09, 6'h0c, 6'h19,
    6'h1f, 6'h03, 6'h07, 6'h0d, 6'h0f, 6'h15};
int miscompares = 0, checks_done = 0;
always #50 core_clk = ~core_clk;
iorb_bank i_iorb_bank (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata), .bit_set(bit_set), .bit_clr(bit_clr),
    .bit_sel(bit_sel), .bit_value(bit_value), .bit_access_error(bit_access_error), .port_pins(port_pins),
    .conv_result(conv_result), .conv_done(conv_done), .cmp_out(cmp_out), .cmp_event(cmp_event),
    .ser_events(ser_events), .ser_buffer(ser_buffer), .port_out(port_out), .port_dir(port_dir),
    .pc_mask(pc_mask), .din_disable(din_disable), .conv_csa(conv_csa), .conv_csb(conv_csb),
    .conv_mux(conv_mux), .cmp_ctrl(cmp_ctrl), .ser_ctrl(ser_ctrl), .ser_data(ser_data),
    .ser_count(ser_count));
iorb_core_model i_iorb_core_model (.core_clk(core_clk), .io_rdata(io_rdata), .bit_value(bit_value),
    .bit_access_error(bit_access_error), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rd(io_rd), .bit_set(bit_set), .bit_clr(bit_clr), .bit_sel(bit_sel));
// ====
// helpers
function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction
// writable bits of the places the random loop visits; reserved places have none
function logic [7:0] msk(input logic [5:0] x);
    case (x)
        6'h03: return 8'he7;
        6'h07, 6'h0d, 6'h0f, 6'h11, 6'h12, 6'h13: return 8'hff;
        6'h14, 6'h15, 6'h17, 6'h18: return 8'h3f;
        default: return 8'h00;
    endcase
endfunction
task run(input logic [1:0] k, input logic [5:0] x, input logic [7:0] y);
    i_iorb_core_model.op(k, x, y, q, bv, er);
endtask
task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
        miscompares++;
        $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
endtask
task chkb(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
endtask
task results;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
initial begin
    #2000000;
    miscompares++;
    results();
end
// ====
// scenarios
initial begin
    for (int i = 0; i < 64; i++) m[i] = 8'h00;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (300) begin
        r = xs();
        a = tbl[r[4:0] % 17];
        d = r[15:8];
        k = r[17:16];
        mk = msk(a);
        // reserved places are only read, reserved bits are only written as zero
        if (k != 2'h0 && mk[d[2:0]] == 1'b0) k = 2'h0;
        if (k == 2'h1) d = d & mk;
        run(k, a, d);
        chkb(bv, m[a][d[2:0]]);
        chkb(er, 1'b0);
        if (k == 2'h0) chk(q, m[a]);
        if (k == 2'h1) m[a] = d;
        if (k == 2'h2) m[a] = m[a] | (8'h01 << d[2:0]);
        if (k == 2'h3) m[a] = m[a] & ~(8'h01 << d[2:0]);
    end
    chk(port_out, m[6'h18]);
    chk(port_dir, m[6'h17]);
    chk(pc_mask, m[6'h15]);
    chk(din_disable, m[6'h14]);
    chk(conv_csb, m[6'h03]);
    chk(conv_mux, m[6'h07]);
    chk(ser_ctrl, m[6'h0d]);
    chk(ser_data, m[6'h0f]);
    run(2'h1, 6'h18, 8'h00);
    run(2'h1, 6'h38, 8'h7e);
    run(2'h2, 6'h38, 8'h00);
    chkb(er, 1'b1);
    chkb(bv, 1'b0);
    run(2'h0, 6'h18, 8'h00);
    chk(q, 8'h00);
    {conv_done, cmp_event, ser_events} = 5'h1f;
    @(negedge core_clk) {conv_done, cmp_event, ser_events} = 5'h00;
    run(2'h2, 6'h06, 8'h00);
    run(2'h0, 6'h06, 8'h00);
    chk(q, 8'h11);
    chk(conv_csa, 8'h01);
    run(2'h1, 6'h06, 8'h00);
    run(2'h0, 6'h06, 8'h00);
    chk(q, 8'h10);
    run(2'h1, 6'h06, 8'h10);
    run(2'h0, 6'h06, 8'h00);
    chk(q, 8'h00);
    run(2'h2, 6'h0e, 8'h06);
    run(2'h3, 6'h0e, 8'h07);
    run(2'h2, 6'h0e, 8'h00);
    run(2'h0, 6'h0e, 8'h00);
    chk(q, 8'ha1);
    chk({4'h0, ser_count}, 8'h01);
    run(2'h2, 6'h08, 8'h04);
    chkb(bv, 1'b1);
    run(2'h0, 6'h08, 8'h04);
    chkb(bv, 1'b0);
    run(2'h1, 6'h08, 8'hfb);
    chk(cmp_ctrl, 8'hcb);
    r = xs();
    {ser_buffer, cmp_out, conv_result, port_pins} = {r[31:24], r[18], r[17:8], r[7:0]};
    repeat (3) @(negedge core_clk);
    run(2'h0, 6'h16, 8'h05);
    chk(q, {2'h0, r[5:0]});
    chkb(bv, r[5]);
    run(2'h0, 6'h04, 8'h00);
    chk(q, r[15:8]);
    run(2'h0, 6'h05, 8'h00);
    chk(q, {6'h0, r[17:16]});
    run(2'h0, 6'h10, 8'h05);
    chk(q, r[31:24]);
    run(2'h0, 6'h08, 8'h05);
    chkb(bv, r[18]);
    results();
end
endmodule // tb_top
`default_nettype wire
